// ### design/pcg_cfg.svh
// Constants for the loop clock generator control block.
// Assumes APB with 32-bit data; one register per aligned word.
`ifndef PCG_CFG_SVH
`define PCG_CFG_SVH
`define PCG_ADDR_W 12
`define PCG_OFF_CTRL 12'h000
`define PCG_OFF_BW 12'h004
`define PCG_OFF_MULT 12'h008
`define PCG_OFF_RANGE 12'h00c
`define PCG_OFF_REFDIV 12'h010
`define PCG_OFF_LDIN 12'h014
// Control register fields
`define PCG_CTL_IE 7
`define PCG_CTL_IF 6
`define PCG_CTL_ON 5
`define PCG_CTL_BCS 4
`define PCG_CTL_PRE_LO 2
`define PCG_CTL_VPR_LO 0
// Bandwidth register fields
`define PCG_BW_AUTO 7
`define PCG_BW_LOCK 6
`define PCG_BW_TRK 5
// Divider widths
`define PCG_N_W 12
`define PCG_R_W 4
`define PCG_L_W 8
`define PCG_CTL_RST 8'h20
`define PCG_N_RST 12'h040
`define PCG_L_RST 8'h40
`define PCG_R_RST 4'h1
// Selector stasis: waits for three cycles of the oscillator, and of the loop source while the loop runs
`define PCG_STASIS 2'd3
`endif

// ### design/pcg_pkg.sv
// Types for the loop clock generator control block.
// Constants live in pcg_cfg.svh.
package pcg_pkg;
	typedef struct packed
	{
		logic [1:0] pre;
		logic [1:0] vpr;
		logic [11:0] mult;
		logic [7:0] range;
		logic [3:0] refdiv;
	} pcg_prog_t;
	typedef enum logic [1:0]
	{
		SEL_OSC = 2'b00,
		SEL_HOLD = 2'b01,
		SEL_LOOP = 2'b10
	} pcg_sel_t;
endpackage : pcg_pkg

// ### design/pcg_moddiv.sv
// Modulo divider: one-cycle tick every max(div,1) input ticks.
// Assumes a synchronous tick input in the pclk domain.
`timescale 1ns/100ps
`default_nettype none
module pcg_moddiv #(parameter int W = 12)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick_in,
	input wire logic [W-1:0] div,
	output logic tick_out
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] lim;
	assign lim = (div == '0) ? W'(1) : div;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_r <= '0;
		else if (tick_in)
			cnt_r <= (cnt_r + W'(1) >= lim) ? '0 : cnt_r + W'(1);
	end
	assign tick_out = tick_in && (cnt_r + W'(1) >= lim);
endmodule : pcg_moddiv
`default_nettype wire

// ### design/pcg_ctrl.sv
// Loop clock generator control: registers, dividers, lock logic, base selector.
// Assumes oscillator and VCO clocks arrive as pins slower than pclk/2.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_cfg.svh"
module pcg_ctrl
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PCG_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic oscillator_clock,
	input wire logic vco_clock,
	output logic base_clock_out,
	output logic prescaled_vco_clock,
	output logic divided_reference_clock,
	output logic feedback_clock,
	output logic pump_up,
	output logic pump_down,
	output logic loop_power,
	output logic filter_tracking_out,
	output pcg_pkg::pcg_prog_t prog_out,
	output logic lock_change_irq
);
	import pcg_pkg::*;
	logic lock_irq_enable_r, lock_irq_flag_r, loop_enable_r, base_source_select_r;
	logic auto_bw_r, lock_r, filter_tracking_bit_r, man_track_r;
	pcg_prog_t prog_r;
	logic [7:0] ld_win_r;
	logic [1:0] xs_r, vs_r;
	logic x_prev_r, v_prev_r;
	logic x_tick, v_tick;
	logic [2:0] pre_cnt_r;
	logic p_tick, r_tick, f_tick;
	logic pclk_half_r, rdv_r, fdv_r;
	logic wr, rd, loop_ok;
	logic [31:0] rdata;
	logic ctl_hit;
	logic want_bcs, want_on;
	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xs_r <= 2'b00;
			vs_r <= 2'b00;
			x_prev_r <= 1'b0;
			v_prev_r <= 1'b0;
		end
		else
		begin
			xs_r <= {xs_r[0], oscillator_clock};
			vs_r <= {vs_r[0], vco_clock};
			x_prev_r <= xs_r[1];
			v_prev_r <= vs_r[1];
		end
	end
	assign x_tick = xs_r[1] && !x_prev_r;
	assign v_tick = vs_r[1] && !v_prev_r && loop_enable_r;
	assign loop_ok = loop_enable_r && (prog_r.range != 8'h00);
	// Prescaler 2^P
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_cnt_r <= 3'd0;
		else if (v_tick)
			pre_cnt_r <= pre_cnt_r + 3'd1;
	end
	always_comb
	begin
		case (prog_r.pre)
			2'd0: p_tick = v_tick;
			2'd1: p_tick = v_tick && pre_cnt_r[0];
			2'd2: p_tick = v_tick && (pre_cnt_r[1:0] == 2'b11);
			default: p_tick = v_tick && (pre_cnt_r == 3'b111);
		endcase
	end
	pcg_moddiv #(.W(`PCG_R_W)) u_refdiv
	(
		.pclk(pclk),
		.presetn(presetn),
		.tick_in(x_tick),
		.div(prog_r.refdiv),
		.tick_out(r_tick)
	);
	pcg_moddiv #(.W(`PCG_N_W)) u_fbdiv
	(
		.pclk(pclk),
		.presetn(presetn),
		.tick_in(p_tick),
		.div(prog_r.mult),
		.tick_out(f_tick)
	);
	// Divided clocks as toggles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdv_r <= 1'b0;
			fdv_r <= 1'b0;
			pclk_half_r <= 1'b0;
		end
		else
		begin
			if (r_tick)
				rdv_r <= !rdv_r;
			if (f_tick)
				fdv_r <= !fdv_r;
			if (p_tick)
				pclk_half_r <= !pclk_half_r;
		end
	end
	// Phase detector: pulse from earlier edge until later edge
	logic pd_up_r, pd_dn_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pd_up_r <= 1'b0;
			pd_dn_r <= 1'b0;
		end
		else if (!loop_enable_r || (r_tick && f_tick) || (pd_up_r && f_tick) || (pd_dn_r && r_tick))
		begin
			pd_up_r <= 1'b0;
			pd_dn_r <= 1'b0;
		end
		else if (r_tick)
			pd_up_r <= 1'b1;
		else if (f_tick)
			pd_dn_r <= 1'b1;
	end
	// Lock detector: feedback ticks per reference tick
	logic [7:0] fcnt_r;
	logic det_in_r, det_lock_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fcnt_r <= 8'h00;
			det_in_r <= 1'b0;
			det_lock_r <= 1'b0;
		end
		else if (!loop_ok)
		begin
			fcnt_r <= 8'h00;
			det_in_r <= 1'b0;
			det_lock_r <= 1'b0;
		end
		else if (r_tick)
		begin
			fcnt_r <= 8'h00;
			det_in_r <= (fcnt_r + 8'(f_tick)) == 8'h01;
			det_lock_r <= det_in_r && ((fcnt_r + 8'(f_tick)) == 8'h01);
		end
		else if (f_tick && fcnt_r != 8'hff)
			fcnt_r <= fcnt_r + 8'h01;
	end
	// Two stage retiming of detector results
	logic [1:0] trk_s_r, lck_s_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trk_s_r <= 2'b00;
			lck_s_r <= 2'b00;
		end
		else
		begin
			trk_s_r <= {trk_s_r[0], det_in_r};
			lck_s_r <= {lck_s_r[0], det_lock_r};
		end
	end
	// APB decode
	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	assign ctl_hit = wr && (paddr == `PCG_OFF_CTRL);
	assign want_on = pwdata[`PCG_CTL_ON];
	assign want_bcs = pwdata[`PCG_CTL_BCS];
	// Control register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			loop_enable_r <= 1'b1;
			base_source_select_r <= 1'b0;
			lock_irq_enable_r <= 1'b0;
		end
		else
		begin
			if (!auto_bw_r)
				lock_irq_enable_r <= 1'b0;
			else if (ctl_hit)
				lock_irq_enable_r <= pwdata[`PCG_CTL_IE];
			if (ctl_hit && !((want_on != loop_enable_r) && (want_bcs != base_source_select_r)))
			begin
				if (!base_source_select_r)
					loop_enable_r <= want_on;
				if (loop_ok && want_on == loop_enable_r)
					base_source_select_r <= want_bcs;
				else if (!want_bcs)
					base_source_select_r <= 1'b0;
			end
			else if (!loop_ok)
				base_source_select_r <= 1'b0;
		end
	end
	// Programming registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prog_r.pre <= 2'd0;
			prog_r.vpr <= 2'd0;
			prog_r.mult <= `PCG_N_RST;
			prog_r.range <= `PCG_L_RST;
			prog_r.refdiv <= `PCG_R_RST;
		end
		else if (wr && !loop_enable_r)
		begin
			if (paddr == `PCG_OFF_CTRL)
			begin
				prog_r.pre <= pwdata[`PCG_CTL_PRE_LO +: 2];
				prog_r.vpr <= pwdata[`PCG_CTL_VPR_LO +: 2];
			end
			else if (paddr == `PCG_OFF_MULT)
				prog_r.mult <= pwdata[`PCG_N_W-1:0];
			else if (paddr == `PCG_OFF_RANGE)
				prog_r.range <= pwdata[`PCG_L_W-1:0];
			else if (paddr == `PCG_OFF_REFDIV)
				prog_r.refdiv <= pwdata[`PCG_R_W-1:0];
		end
	end
	// Bandwidth, lock and flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			auto_bw_r <= 1'b0;
			man_track_r <= 1'b0;
			lock_r <= 1'b0;
			lock_irq_flag_r <= 1'b0;
		end
		else
		begin
			if (wr && paddr == `PCG_OFF_BW)
			begin
				auto_bw_r <= pwdata[`PCG_BW_AUTO];
				man_track_r <= pwdata[`PCG_BW_TRK];
			end
			if (!auto_bw_r)
			begin
				lock_r <= 1'b0;
				lock_irq_flag_r <= 1'b0;
			end
			else
			begin
				lock_r <= lck_s_r[1];
				if (lck_s_r[1] != lock_r)
					lock_irq_flag_r <= 1'b1;
				else if (rd && penable && paddr == `PCG_OFF_CTRL)
					lock_irq_flag_r <= 1'b0;
			end
		end
	end
	always_comb
	begin
		if (auto_bw_r)
			filter_tracking_bit_r = trk_s_r[1];
		else
			filter_tracking_bit_r = man_track_r;
	end
	// Read mux
	always_comb
	begin
		rdata = 32'h0000_0000;
		if (paddr == `PCG_OFF_CTRL)
		begin
			rdata[`PCG_CTL_IE] = lock_irq_enable_r;
			rdata[`PCG_CTL_IF] = lock_irq_flag_r && auto_bw_r;
			rdata[`PCG_CTL_ON] = loop_enable_r;
			rdata[`PCG_CTL_BCS] = base_source_select_r;
			rdata[`PCG_CTL_PRE_LO +: 2] = prog_r.pre;
			rdata[`PCG_CTL_VPR_LO +: 2] = prog_r.vpr;
		end
		else if (paddr == `PCG_OFF_BW)
		begin
			rdata[`PCG_BW_AUTO] = auto_bw_r;
			rdata[`PCG_BW_LOCK] = lock_r && auto_bw_r;
			rdata[`PCG_BW_TRK] = filter_tracking_bit_r;
		end
		else if (paddr == `PCG_OFF_MULT)
			rdata[`PCG_N_W-1:0] = prog_r.mult;
		else if (paddr == `PCG_OFF_RANGE)
			rdata[`PCG_L_W-1:0] = prog_r.range;
		else if (paddr == `PCG_OFF_REFDIV)
			rdata[`PCG_R_W-1:0] = prog_r.refdiv;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (paddr > `PCG_OFF_REFDIV);
			if (rd && !penable)
				prdata <= rdata;
		end
	end
	// Base clock selector with stasis
	pcg_sel_t sel_st_r;
	logic [1:0] xw_r, pw_r;
	logic src_r, out_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sel_st_r <= SEL_OSC;
			xw_r <= 2'd0;
			pw_r <= 2'd0;
			src_r <= 1'b0;
			out_r <= 1'b0;
		end
		else
		begin
			case (sel_st_r)
				SEL_OSC, SEL_LOOP:
				begin
					if (base_source_select_r != src_r)
					begin
						sel_st_r <= SEL_HOLD;
						xw_r <= 2'd0;
						pw_r <= 2'd0;
					end
					else if (src_r ? p_tick : x_tick)
						out_r <= !out_r;
				end
				SEL_HOLD:
				begin
					if (x_tick && xw_r != `PCG_STASIS)
						xw_r <= xw_r + 2'd1;
					if (p_tick && pw_r != `PCG_STASIS)
						pw_r <= pw_r + 2'd1;
					if (xw_r == `PCG_STASIS && (pw_r == `PCG_STASIS || !loop_ok))
					begin
						src_r <= base_source_select_r;
						sel_st_r <= base_source_select_r ? SEL_LOOP : SEL_OSC;
					end
				end
				default: sel_st_r <= SEL_OSC;
			endcase
		end
	end
	// Registered outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			base_clock_out <= 1'b0;
			prescaled_vco_clock <= 1'b0;
			divided_reference_clock <= 1'b0;
			feedback_clock <= 1'b0;
			pump_up <= 1'b0;
			pump_down <= 1'b0;
			loop_power <= 1'b0;
			filter_tracking_out <= 1'b0;
			prog_out <= '0;
			lock_change_irq <= 1'b0;
		end
		else
		begin
			base_clock_out <= out_r;
			prescaled_vco_clock <= pclk_half_r;
			divided_reference_clock <= rdv_r;
			feedback_clock <= fdv_r;
			pump_up <= pd_up_r;
			pump_down <= pd_dn_r;
			loop_power <= loop_ok;
			filter_tracking_out <= filter_tracking_bit_r;
			prog_out <= prog_r;
			lock_change_irq <= lock_irq_flag_r && lock_irq_enable_r && auto_bw_r;
		end
	end
endmodule : pcg_ctrl
`default_nettype wire

// ### testbench/pcg_ctrl_sva.sv
// Port checker for the loop clock generator control block.
// Assumes an APB master keeping the bus protocol.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_cfg.svh"
module pcg_ctrl_sva
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PCG_ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic loop_power,
	input wire pcg_pkg::pcg_prog_t prog_out,
	input wire logic lock_change_irq
);
	import pcg_pkg::*;
	logic rd_ctrl;
	logic rd_bw;
	assign rd_ctrl = pready && !pwrite && paddr == `PCG_OFF_CTRL;
	assign rd_bw = pready && !pwrite && paddr == `PCG_OFF_BW;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_ONLY_BAD: assert property (pslverr |-> pready && paddr > 12'h010 && prdata == 32'h0)
		else $error("pslverr on a mapped address");
	AST_ERR_BAD_ADDR: assert property (pready && paddr > 12'h010 |-> pslverr)
		else $error("unmapped address not refused");
	AST_LOCK_MANUAL_CLEAR: assert property (rd_bw && !prdata[`PCG_BW_AUTO] |-> !prdata[`PCG_BW_LOCK])
		else $error("lock reads set in manual mode");
	AST_BCS_NEEDS_POWER: assert property (rd_ctrl && !$past(loop_power) |-> !prdata[`PCG_CTL_BCS])
		else $error("base select set without loop power");
	AST_BCS_HOLDS_ON: assert property (rd_ctrl && prdata[`PCG_CTL_BCS] |-> prdata[`PCG_CTL_ON])
		else $error("base select set with loop off");
	AST_PROG_FROZEN: assert property (loop_power && $past(loop_power) |=> $stable(prog_out))
		else $error("programming changed while loop on");
	AST_IRQ_NEEDS_IE: assert property (rd_ctrl && $past(lock_change_irq) |-> prdata[7:6] == 2'h3)
		else $error("interrupt without enable and flag");
	cover property (rd_ctrl && prdata[`PCG_CTL_BCS]);
	cover property (lock_change_irq);
	cover property (pslverr);
endmodule : pcg_ctrl_sva
`default_nettype wire

// ### testbench/pcg_clk_src.sv
// Free running oscillator and VCO sources for the control block.
// Assumes a 1ns time unit; VCO runs at twice the oscillator rate.
`timescale 1ns/100ps
`default_nettype none
module pcg_clk_src #(parameter int OSC_HALF = 400, parameter int VCO_HALF = 200)
(
	output var logic oscillator_clock,
	output var logic vco_clock
);
	initial
	begin
		oscillator_clock = 1'h0;
		vco_clock = 1'h0;
		#7;
		forever #(VCO_HALF) vco_clock = ~vco_clock;
	end
	always #(OSC_HALF) oscillator_clock = ~oscillator_clock;
endmodule : pcg_clk_src
`default_nettype wire

// ### testbench/pcg_ctrl_test.sv
// Self-checking bench for the loop clock generator control block.
// Assumes pcg_pkg, pcg_ctrl, pcg_clk_src and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_cfg.svh"
module pcg_ctrl_test;
	import pcg_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
	logic osc, vco, base, pvco, dref, fb, pu, pd, lpow, trk, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	pcg_prog_t prog;
	int errors, comparisons;
	pcg_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.oscillator_clock(osc), .vco_clock(vco), .base_clock_out(base), .prescaled_vco_clock(pvco),
		.divided_reference_clock(dref), .feedback_clock(fb), .pump_up(pu), .pump_down(pd),
		.loop_power(lpow), .filter_tracking_out(trk), .prog_out(prog), .lock_change_irq(irq));
	pcg_clk_src src (.oscillator_clock(osc), .vco_clock(vco));
	always #12.5 pclk = ~pclk;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		if (n >= 20)
			check(32'h0, 32'h1);
		q = prdata;
		err_seen = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
		apb(a, 1'h1, d);
		apb(a, 1'h0, 32'h0);
		check(q, e);
	endtask : wrc
	task automatic test_reset;
		logic [11:0] ra [5] = '{`PCG_OFF_CTRL, `PCG_OFF_BW, `PCG_OFF_MULT, `PCG_OFF_RANGE, `PCG_OFF_REFDIV};
		logic [31:0] rv [5] = '{32'h20, 32'h0, 32'h40, 32'h40, 32'h1};
		for (int i = 0; i < 5; i++)
		begin
			apb(ra[i], 1'h0, 32'h0);
			check(q, rv[i]);
		end
		$display("test reset done");
	endtask : test_reset
	task automatic test_interlock;
		wrc(`PCG_OFF_CTRL, 32'h10, 32'h20);
		wrc(`PCG_OFF_CTRL, 32'h30, 32'h30);
		wrc(`PCG_OFF_CTRL, 32'h10, 32'h30);
		wrc(`PCG_OFF_CTRL, 32'h20, 32'h20);
		wrc(`PCG_OFF_CTRL, 32'h00, 32'h00);
		wrc(`PCG_OFF_CTRL, 32'h10, 32'h00);
		$display("test interlock done");
	endtask : test_interlock
	task automatic test_prog;
		wrc(`PCG_OFF_MULT, 32'h0, 32'h0);
		wrc(`PCG_OFF_RANGE, 32'h0, 32'h0);
		wrc(`PCG_OFF_CTRL, 32'h20, 32'h20);
		check({31'h0, lpow}, 32'h0);
		wrc(`PCG_OFF_CTRL, 32'h30, 32'h20);
		wrc(`PCG_OFF_MULT, 32'h123, 32'h0);
		apb(12'h014, 1'h0, 32'h0);
		check({31'h0, err_seen}, 32'h1);
		check(q, 32'h0);
		wrc(`PCG_OFF_CTRL, 32'h00, 32'h00);
		$display("test prog done");
	endtask : test_prog
	task automatic test_lock;
		int nb, np, nr, nf, nu, nx;
		logic pb, pp, pr, pf;
		wrc(`PCG_OFF_MULT, 32'h2, 32'h2);
		wrc(`PCG_OFF_RANGE, 32'h1, 32'h1);
		wrc(`PCG_OFF_BW, 32'h0, 32'h0);
		wrc(`PCG_OFF_CTRL, 32'h80, 32'h00);
		apb(`PCG_OFF_BW, 1'h1, 32'h80);
		apb(`PCG_OFF_CTRL, 1'h1, 32'ha0);
		repeat (1500) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		apb(`PCG_OFF_BW, 1'h0, 32'h0);
		check({29'h0, q[7:5]}, 32'h7);
		check({31'h0, trk}, 32'h1);
		apb(`PCG_OFF_CTRL, 1'h0, 32'h0);
		check(q, 32'he0);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		apb(`PCG_OFF_CTRL, 1'h1, 32'hb0);
		repeat (3) @(posedge pclk);
		nb = 0;
		pb = base;
		repeat (56)
		begin
			@(posedge pclk);
			nb += int'(base !== pb);
			pb = base;
		end
		check(nb, 32'h0);
		repeat (100) @(posedge pclk);
		nb = 0;
		np = 0;
		nr = 0;
		nf = 0;
		nu = 0;
		nx = 0;
		pb = base;
		pp = pvco;
		pr = dref;
		pf = fb;
		repeat (640)
		begin
			@(posedge pclk);
			nb += int'(base !== pb);
			np += int'(pvco !== pp);
			nr += int'(dref !== pr);
			nf += int'(fb !== pf);
			nu += int'(pu || pd);
			nx += int'(pu && pd);
			pb = base;
			pp = pvco;
			pr = dref;
			pf = fb;
		end
		check({31'h0, nb >= 39 && nb <= 41}, 32'h1);
		check({31'h0, np >= 39 && np <= 41}, 32'h1);
		check({31'h0, nr >= 19 && nr <= 21}, 32'h1);
		check({31'h0, nf >= 19 && nf <= 21}, 32'h1);
		check({31'h0, nu > 0}, 32'h1);
		check(nx, 32'h0);
		wrc(`PCG_OFF_BW, 32'h0, 32'h0);
		check({31'h0, irq}, 32'h0);
		$display("test lock done");
	endtask : test_lock
	task automatic test_manual;
		apb(`PCG_OFF_CTRL, 1'h0, 32'h0);
		check(q, 32'h30);
		wrc(`PCG_OFF_CTRL, 32'h20, 32'h20);
		wrc(`PCG_OFF_CTRL, 32'h00, 32'h00);
		wrc(`PCG_OFF_CTRL, 32'h20, 32'h20);
		repeat (100) @(posedge pclk);
		wrc(`PCG_OFF_BW, 32'h20, 32'h20);
		repeat (2) @(posedge pclk);
		check({31'h0, trk}, 32'h1);
		repeat (100) @(posedge pclk);
		wrc(`PCG_OFF_CTRL, 32'h30, 32'h30);
		check({31'h0, irq}, 32'h0);
		$display("test manual done");
	endtask : test_manual
	task conclude;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	initial
	begin
		pclk = 1'h0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		errors = 0;
		comparisons = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		test_reset();
		test_interlock();
		test_prog();
		test_lock();
		test_manual();
		conclude();
	end
	initial
	begin
		#250000;
		errors++;
		conclude();
	end
endmodule : pcg_ctrl_test
bind pcg_ctrl pcg_ctrl_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.loop_power(loop_power), .prog_out(prog_out), .lock_change_irq(lock_change_irq));
`default_nettype wire
